// >>> core/rbp_pkg.sv
// Purpose: Shared constants for the receive backplane pin function select block
// Assumes: APB register map, one aligned 32-bit word per register
// Notes: Field positions refer to the control, mode and status registers and the buffered bit word
package rbp_pkg;
    localparam int unsigned RBP_ADDR_W = 8;
    localparam logic [7:0] RBP_OFS_CTRL = 8'h00;
    localparam logic [7:0] RBP_OFS_FRAC = 8'h04;
    localparam logic [7:0] RBP_OFS_STAT = 8'h08;
    localparam logic [7:0] RBP_OFS_MODE = 8'h0c;
    // Control register fields
    localparam int unsigned CTRL_CLK_SEL = 7;
    localparam int unsigned CTRL_RSVD = 6;
    localparam int unsigned CTRL_PLCLK = 5;
    localparam int unsigned CTRL_FSE = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'hbf;
    // Mode register fields
    localparam int unsigned MODE_SERCLK_OUT = 0;
    localparam int unsigned MODE_SIG_EN = 1;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [23:0] FRAC_RESET = 24'h000000;
    // Status register fields
    localparam int unsigned STAT_OVF = 0;
    localparam int unsigned STAT_EMPTY = 1;
    localparam int unsigned STAT_TS_LSB = 8;
    // T1 frame: one overhead bit then 24 timeslots of 8 bits
    localparam logic [7:0] FRAME_BITS = 8'd193;
    localparam logic [7:0] HALF_FRAME = 8'd97;
    localparam int unsigned TS_BITS = 8;
    // Buffered word: {overhead, data, fractional, frame_first, ts[4:0]}
    localparam int unsigned WORD_W = 9;
    localparam int unsigned W_OVH = 8;
    localparam int unsigned W_DATA = 7;
    localparam int unsigned W_FRAC = 6;
    localparam int unsigned W_FIRST = 5;
    localparam int unsigned FIFO_DEPTH = 8;
    // Output bit cell: low then high half, in mclk cycles
    localparam logic [1:0] SER_HALF = 2'd1;
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_LOW = 3'b010,
        SEQ_HIGH = 3'b100
    } rbp_seq_t;
endpackage

// >>> core/rbp_fifo.sv
// Purpose: Small flop FIFO between line capture and backplane shifter
// Assumes: Single clock, asynchronous active-low reset
// Notes: Depth must be a power of two
module rbp_fifo #(
    parameter int unsigned WIDTH = 9,
    parameter int unsigned DEPTH = 8
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wr;
        logic [AW:0] rd;
    } rbp_fifo_st_t;
    rbp_fifo_st_t q, d;
    logic full, empty;

    assign empty = (q.wr == q.rd);
    assign full = (q.wr[AW-1:0] == q.rd[AW-1:0]) && (q.wr[AW] != q.rd[AW]);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = q.mem[q.rd[AW-1:0]];

    always_comb begin
        d = q;
        if (in_valid_i && !full) begin
            d.mem[q.wr[AW-1:0]] = in_data_i;
            d.wr = q.wr + 1'b1;
        end
        if (out_ready_i && !empty) begin
            d.rd = q.rd + 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    chk_fifo_count: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        ((q.wr - q.rd) <= (AW+1)'(DEPTH)))
        else $error("FIFO occupancy beyond depth");
endmodule

// >>> core/rbp_pin_select.sv
// Purpose: Receive backplane pin function select for one T1 channel
// Assumes: Recovered line clock and data arrive asynchronously, 10 MHz mclk
// Notes: Bits are buffered and replayed faster than line rate, so the
// Notes: serial clock is bursty around each line bit rather than evenly spaced
//
// Decided for this implementation: the APB interface to the registers and the register offsets.

// Behaviour
// - Clock select picks fractional data clock pin
// - Select one: channel clock marks fractional bits
// - Base, fractional off: identifier pins show timeslot
// - Fractional interface needs enable bit set
// - Payload bit zero: continuous serial clock
// - Base, payload bit one: no clock on overhead
// - Fast modes: bit sets strobe polarity
// - Base, enable zero: parallel timeslot number
// - Base, enable one: pin0 signaling
// - Base, enable one: pin1 fractional data
// - Pin2 serial channel, pin3 8 kHz
// - Pin4 recovered line clock
// - Fast modes ignore fractional enable bit
// - Fast modes: pin0 signaling, pin4 clock
// - Multiplexed mode only selects the fast pin roles; four-channel interleave is upstream
module rbp_pin_select (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [rbp_pkg::RBP_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic highspeed_mode_i,
    input wire logic multiplexed_mode_enable_i,
    input wire logic line_clk_i,
    input wire logic line_data_i,
    output logic backplane_serial_data_o,
    output logic rx_serial_clock_pin_o,
    output logic rx_serial_clock_pin_oe_n_o,
    output logic channel_clock_pin_o,
    output logic frame_boundary_strobe_o,
    output logic [4:0] timeslot_identifier_pins_o
);
    import rbp_pkg::*;
    typedef struct packed {
        logic [2:0] clk_sync;
        logic [2:0] dat_sync;
        logic clk_lvl;
        logic [7:0] bitcnt;
        logic [7:0] ctrl;
        logic [23:0] frac;
        logic [1:0] mode;
        logic ovf;
        logic [31:0] rdata;
        logic err;
        rbp_seq_t seq;
        logic [1:0] phase;
        logic [WORD_W-1:0] word;
        logic ser_data;
        logic ser_clk;
        logic ch_clk;
        logic sync;
        logic [4:0] tsid;
        logic [7:0] wpos;
    } rbp_st_t;
    rbp_st_t q, d;

    logic fast_mode, base_fse, clk_rise, push, push_ready;
    logic pop_valid, pop, wr_acc, rd_setup;
    logic [WORD_W-1:0] push_word, pop_word;
    logic [4:0] cur_ts;

    // Byte address decode shared by read and write paths
    function automatic logic [1:0] reg_index(input logic [7:0] a, output logic hit);
        hit = (a == RBP_OFS_CTRL) || (a == RBP_OFS_FRAC) ||
              (a == RBP_OFS_STAT) || (a == RBP_OFS_MODE);
        reg_index = a[3:2];
    endfunction

    // Timeslot and bit position from the frame bit counter
    function automatic logic [7:0] ts_pos(input logic [7:0] bc);
        logic [7:0] p;
        p = bc - 8'd1;
        ts_pos = p;
    endfunction

    // Four-channel interleave happens upstream; mux only picks fast pin roles
    assign fast_mode = highspeed_mode_i || multiplexed_mode_enable_i;
    // Enable bit only matters in base rate; fast modes never look at it
    assign base_fse = !fast_mode && q.ctrl[CTRL_FSE];
    assign clk_rise = (q.clk_sync[2] == q.clk_sync[1]) && q.clk_sync[2] && !q.clk_lvl;

    always_comb begin
        logic [7:0] p;
        p = ts_pos(q.bitcnt);
        cur_ts = p[7:3];
    end

    assign push = clk_rise;
    assign push_word = {q.bitcnt == 8'd0, q.dat_sync[2],
                        (q.bitcnt != 8'd0) && q.frac[cur_ts], q.bitcnt == 8'd0,
                        q.bitcnt == 8'd0 ? 5'd0 : cur_ts};
    assign pop = (q.seq == SEQ_IDLE) && pop_valid;

    rbp_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .in_valid_i(push),
        .in_ready_o(push_ready),
        .in_data_i(push_word),
        .out_valid_o(pop_valid),
        .out_ready_i(pop),
        .out_data_o(pop_word)
    );

    assign rd_setup = psel_i && !penable_i && !pwrite_i;
    assign wr_acc = psel_i && penable_i && pwrite_i;
    // Access phase always completes in its first cycle
    assign pready_o = psel_i && penable_i;
    assign pslverr_o = pready_o && q.err;
    assign prdata_o = q.rdata;
    assign backplane_serial_data_o = q.ser_data;
    assign rx_serial_clock_pin_o = q.ser_clk;
    assign rx_serial_clock_pin_oe_n_o = !q.mode[MODE_SERCLK_OUT];
    assign channel_clock_pin_o = q.ch_clk;
    assign frame_boundary_strobe_o = q.sync;
    assign timeslot_identifier_pins_o = q.tsid;

    always_comb begin
        logic hit;
        logic [1:0] idx;
        logic [WORD_W-1:0] w;
        logic frac_bit, sig_bit;
        logic [4:0] wts;
        logic [7:0] p;
        logic [7:0] wpos_n;
        d = q;
        hit = 1'b0;
        idx = reg_index(paddr_i, hit);
        w = pop_word;
        frac_bit = 1'b0;
        sig_bit = 1'b0;
        wts = '0;
        p = 8'd0;
        wpos_n = q.wpos;

        // Three-stage input capture; stage 0 feeds only stage 1
        d.clk_sync = {q.clk_sync[1:0], line_clk_i};
        d.dat_sync = {q.dat_sync[1:0], line_data_i};
        if (q.clk_sync[2] == q.clk_sync[1]) begin
            d.clk_lvl = q.clk_sync[2];
        end
        if (clk_rise) begin
            d.bitcnt = (q.bitcnt == FRAME_BITS - 8'd1) ? 8'd0 : q.bitcnt + 8'd1;
        end
        // Set wins over a write-one clear in the same cycle
        if (push && !push_ready) begin
            d.ovf = 1'b1;
        end else if (wr_acc && hit && idx == RBP_OFS_STAT[3:2] && pwdata_i[STAT_OVF]) begin
            d.ovf = 1'b0;
        end

        // APB: read data latched in setup, write taken in access
        if (psel_i && !penable_i) begin
            d.err = !hit;
        end
        if (rd_setup) begin
            d.rdata = '0;
            case (idx)
                2'd0: d.rdata[7:0] = q.ctrl & CTRL_WMASK;
                2'd1: d.rdata[23:0] = q.frac;
                2'd2: begin
                    d.rdata[STAT_OVF] = q.ovf;
                    d.rdata[STAT_EMPTY] = !pop_valid;
                    d.rdata[STAT_TS_LSB +: 5] = cur_ts;
                end
                default: d.rdata[1:0] = q.mode;
            endcase
            if (!hit) begin
                d.rdata = '0;
            end
        end
        if (wr_acc && hit) begin
            case (idx)
                2'd0: d.ctrl = pwdata_i[7:0] & CTRL_WMASK;
                2'd1: d.frac = pwdata_i[23:0];
                2'd2: d.frac = q.frac;
                default: d.mode = pwdata_i[1:0];
            endcase
        end

        // Backplane bit cell sequencer
        case (q.seq)
            SEQ_IDLE: begin
                if (pop) begin
                    d.word = w;
                    d.seq = SEQ_LOW;
                    d.phase = SER_HALF;
                    d.ser_clk = 1'b0;
                    d.ser_data = w[W_DATA];
                    wts = w[4:0];
                    // Frame position follows the popped word, not the live counter
                    wpos_n = w[W_FIRST] ? 8'd0 : q.wpos + 8'd1;
                    d.wpos = wpos_n;
                    p = ts_pos(wpos_n);
                    frac_bit = base_fse && w[W_FRAC];
                    // Signaling taken from the data bit of payload bits when enabled
                    sig_bit = q.mode[MODE_SIG_EN] && !w[W_OVH] && w[W_DATA];
                    // Strobe polarity only selectable in fast modes
                    if (fast_mode && q.ctrl[CTRL_PLCLK]) begin
                        d.sync = !w[W_FIRST];
                    end else begin
                        d.sync = w[W_FIRST];
                    end
                    if (base_fse && q.ctrl[CTRL_CLK_SEL]) begin
                        d.ch_clk = frac_bit;
                    end else if (base_fse) begin
                        d.ch_clk = 1'b0;
                    end else begin
                        d.ch_clk = !w[W_OVH] && (w[4:0] != q.word[4:0] || q.word[W_OVH]);
                    end
                    if (fast_mode) begin
                        // Enable bit has no say here
                        d.tsid = {q.clk_lvl, wts[3:1], sig_bit};
                    end else if (q.ctrl[CTRL_FSE]) begin
                        d.tsid[0] = sig_bit;
                        d.tsid[1] = frac_bit && w[W_DATA];
                        d.tsid[2] = (p[2:0] < 3'd5) ? wts[3'd4 - p[2:0]] : 1'b0;
                        d.tsid[3] = wpos_n < HALF_FRAME;
                        d.tsid[4] = q.clk_lvl;
                    end else begin
                        d.tsid = wts;
                    end
                end
            end
            SEQ_LOW: begin
                if (q.phase == 2'd1) begin
                    d.seq = SEQ_HIGH;
                    d.phase = SER_HALF;
                    // Gapped clock only in base rate with payload clock chosen
                    d.ser_clk = fast_mode || !q.ctrl[CTRL_PLCLK] ||
                                !q.word[W_OVH];
                    if (base_fse && !q.ctrl[CTRL_CLK_SEL] && q.word[W_FRAC]) begin
                        d.ch_clk = 1'b1;
                    end
                end else begin
                    d.phase = q.phase - 2'd1;
                end
            end
            SEQ_HIGH: begin
                if (q.phase == 2'd1) begin
                    d.seq = SEQ_IDLE;
                    d.ser_clk = 1'b0;
                    if (base_fse && !q.ctrl[CTRL_CLK_SEL]) begin
                        d.ch_clk = 1'b0;
                    end
                end else begin
                    d.phase = q.phase - 2'd1;
                end
            end
            default: d.seq = SEQ_IDLE;
        endcase
        // Recovered clock keeps tracking between bit cells
        if (fast_mode || base_fse) begin
            d.tsid[4] = d.clk_lvl;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '0;
            q.ctrl <= CTRL_RESET;
            q.frac <= FRAC_RESET;
            q.mode <= MODE_RESET;
            q.seq <= SEQ_IDLE;
        end else begin
            q <= d;
        end
    end

    chk_reserved_zero: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (rd_setup && paddr_i == RBP_OFS_CTRL) |=> (prdata_o[CTRL_RSVD] == 1'b0))
        else $error("Reserved control bit read back as one");

    chk_tsid_parallel: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (pop && !fast_mode && !q.ctrl[CTRL_FSE]) |=>
        (timeslot_identifier_pins_o == $past(pop_word[4:0])))
        else $error("Identifier pins do not show timeslot");

    chk_frac_data: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (pop && base_fse) |=>
        (timeslot_identifier_pins_o[1] == $past(pop_word[W_FRAC] && pop_word[W_DATA])))
        else $error("Fractional data pin wrong");

    chk_qualifier_pin: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (pop && base_fse && q.ctrl[CTRL_CLK_SEL]) |=>
        (channel_clock_pin_o == $past(pop_word[W_FRAC])) ##1
        (channel_clock_pin_o == $past(pop_word[W_FRAC], 2)))
        else $error("Channel clock not acting as qualifier");

    chk_gap_clock: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (pop && !fast_mode && q.ctrl[CTRL_PLCLK] && pop_word[W_OVH]) |=>
        !rx_serial_clock_pin_o [*3])
        else $error("Serial clock pulsed on overhead bit");

    chk_cont_clock: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (pop && !fast_mode && !q.ctrl[CTRL_PLCLK]) |=>
        ##1 rx_serial_clock_pin_o ##1 !rx_serial_clock_pin_o)
        else $error("Continuous serial clock missing a pulse");

    chk_sync_pol: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (pop && fast_mode && q.ctrl[CTRL_PLCLK] && pop_word[W_FIRST]) |=>
        !frame_boundary_strobe_o)
        else $error("Frame strobe polarity wrong");

    chk_fast_clock: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        fast_mode |=> (timeslot_identifier_pins_o[4] == q.clk_lvl))
        else $error("Recovered clock missing on pin four");

    chk_base_recovered: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        base_fse |=> (timeslot_identifier_pins_o[4] == q.clk_lvl))
        else $error("Recovered clock missing on pin four in base rate");

    chk_frame_rate: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (pop && base_fse && pop_word[W_FIRST]) |=> timeslot_identifier_pins_o[3])
        else $error("Frame rate pin low at frame start");

    chk_fast_signaling: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (pop && fast_mode && q.mode[MODE_SIG_EN] && !pop_word[W_OVH]) |=>
        (timeslot_identifier_pins_o[0] == $past(pop_word[W_DATA])))
        else $error("Signaling data missing on pin zero");

    chk_fse_ignored: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (pop && fast_mode) |=>
        (timeslot_identifier_pins_o[3:1] == $past(pop_word[3:1])))
        else $error("Fast mode pin roles follow the enable bit");

    chk_strobe_high: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (pop && !(fast_mode && q.ctrl[CTRL_PLCLK])) |=>
        (frame_boundary_strobe_o == $past(pop_word[W_FIRST])))
        else $error("Frame strobe not active high");
endmodule

// >>> sim/rbp_line_model.sv
// Purpose: Recovered T1 line source feeding the pin select block
// Assumes: Bit n carries n[0] ^ n[2] ^ n[5]; first rise after run is bit 0
// Notes: Clock idles low between runs; data flips once released
module rbp_line_model (
    input wire logic run_i,
    input var int nbits_i,
    output logic line_clk_o,
    output logic line_data_o,
    output int bits_o
);
    timeunit 1ns;
    timeprecision 1ns;

    function automatic logic bitval(input int n);
        return n[0] ^ n[2] ^ n[5];
    endfunction

    initial begin
        line_clk_o = 1'b0;
        bits_o = 0;
        line_data_o = bitval(0);
        forever begin
            wait (run_i);
            line_data_o = bitval(0);
            // Odd offset keeps line edges off the mclk grid
            #37;
            while (bits_o < nbits_i) begin
                #400 line_clk_o = 1'b1;
                #400 line_clk_o = 1'b0;
                bits_o = bits_o + 1;
                line_data_o = bitval(bits_o);
            end
            wait (!run_i);
            // Released line must not look like a held last bit
            line_data_o = ~line_data_o;
            bits_o = 0;
        end
    end
endmodule

// >>> sim/tb_rx_backplane_pin_function_select.sv
// Purpose: Self-checking bench for the receive backplane pin select block
// Assumes: Zero-wait APB slave; continuous clock gives one pulse per line bit
// Notes: Each case resets so the frame counter realigns to the first line bit
module tb_rx_backplane_pin_function_select;
    timeunit 1ns;
    timeprecision 1ns;
    import rbp_pkg::*;

    logic mclk_i, resetn_i, psel, penable, pwrite, hs, mux, run;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, line_clk, line_data, ser_data, ser_clk, ser_oe_n, ch_clk, strobe;
    logic [4:0] pins;
    logic mon_on, gapped, fast, ser_q;
    logic [7:0] ctrl;
    logic [1:0] mode;
    int nbits, bits_seen, pulses;
    int miscompares, n_compared;
    logic [7:0] ctrl_tab [6] = '{8'h80, 8'h20, 8'h90, 8'h30, 8'h10, 8'h10};
    logic [1:0] mode_tab [6] = '{2'h1, 2'h1, 2'h3, 2'h3, 2'h3, 2'h3};
    logic hs_tab [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    logic mux_tab [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};

    rbp_pin_select dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .highspeed_mode_i(hs), .multiplexed_mode_enable_i(mux), .line_clk_i(line_clk),
        .line_data_i(line_data), .backplane_serial_data_o(ser_data),
        .rx_serial_clock_pin_o(ser_clk), .rx_serial_clock_pin_oe_n_o(ser_oe_n),
        .channel_clock_pin_o(ch_clk), .frame_boundary_strobe_o(strobe),
        .timeslot_identifier_pins_o(pins));

    rbp_line_model line (.run_i(run), .nbits_i(nbits), .line_clk_o(line_clk),
        .line_data_o(line_data), .bits_o(bits_seen));

    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    function automatic logic fd(input int n);
        return n[0] ^ n[2] ^ n[5];
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int i;
        @(posedge mclk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk_i);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge mclk_i);
            i++;
        end while (pready !== 1'b1 && i < 16);
        if (pready === 1'b1) begin
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end else begin
            miscompares++;
            tally_and_finish();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp,
                          input logic exp_err);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(nm, r, exp);
        check("slave error", {31'h0, e}, {31'h0, exp_err});
    endtask

    task automatic do_reset();
        resetn_i <= 1'b0;
        repeat (5) @(posedge mclk_i);
        resetn_i <= 1'b1;
    endtask

    // Backplane receiver: one line bit per rising serial clock
    always @(posedge mclk_i) begin
        int n, f, j;
        logic [4:0] ts;
        ser_q <= ser_clk;
        if (mon_on && ser_clk === 1'b1 && ser_q === 1'b0) begin
            n = gapped ? (pulses / 192) * 193 + pulses % 192 + 1 : pulses;
            pulses++;
            f = n % 193;
            ts = 5'((f - 1) / 8);
            j = (f - 1) % 8;
            check("serial data", ser_data, fd(n));
            check("frame strobe", strobe, logic'(f == 0) ^ (fast & ctrl[5]));
            if (f > 0 && fast) begin
                check("timeslot bits 3..1", pins[3:1], ts[3:1]);
                check("signaling pin", pins[0], fd(n));
            end else if (f > 0 && !ctrl[4]) begin
                check("timeslot pins", pins, ts);
            end else if (f > 0) begin
                check("signaling pin", pins[0], fd(n));
                check("fractional pin", pins[1], fd(n));
                check("frame rate pin", pins[3], logic'(f < 97));
                if (j < 5) check("serial channel pin", pins[2], ts[4 - j]);
                check("channel qualifier", ch_clk, 1'b1);
            end
        end
    end

    task automatic run_case(input int s);
        int i;
        do_reset();
        hs <= hs_tab[s];
        mux <= mux_tab[s];
        ctrl = ctrl_tab[s];
        mode = mode_tab[s];
        fast = hs_tab[s] | mux_tab[s];
        gapped = !fast && ctrl[5];
        wr(RBP_OFS_CTRL, {24'h0, ctrl});
        wr(RBP_OFS_FRAC, 32'h00ffffff);
        wr(RBP_OFS_MODE, {30'h0, mode});
        rd_chk("fraction mask", RBP_OFS_FRAC, 32'h00ffffff, 1'b0);
        check("serial clock enable", ser_oe_n, 1'b0);
        pulses = 0;
        mon_on = 1'b1;
        run <= 1'b1;
        i = 0;
        while (bits_seen < nbits && i < 5000) begin
            @(posedge mclk_i);
            i++;
        end
        if (i >= 5000) begin
            miscompares++;
            tally_and_finish();
        end
        run <= 1'b0;
        repeat (40) @(posedge mclk_i);
        mon_on = 1'b0;
        // Gapped clock drops the two overhead bits of two frames
        check("clock pulses", pulses, gapped ? 384 : 386);
    endtask

    initial begin
        {psel, penable, pwrite, hs, mux, run, mon_on, gapped, fast} = '0;
        {paddr, pwdata, ctrl, mode} = '0;
        resetn_i = 1'b0;
        nbits = 386;
        miscompares = 0;
        n_compared = 0;
        do_reset();
        check("enable after reset", ser_oe_n, 1'b1);
        rd_chk("control reset", RBP_OFS_CTRL, 32'h0, 1'b0);
        wr(RBP_OFS_CTRL, 32'h000000ff);
        rd_chk("control readback", RBP_OFS_CTRL, 32'h000000bf, 1'b0);
        rd_chk("unmapped read", 8'h10, 32'h0, 1'b1);
        for (int s = 0; s < 6; s++) begin
            run_case(s);
        end
        tally_and_finish();
    end
endmodule
